// ===== rtl/sap_defs.svh
// serial audio port: register offsets, field positions, reset values and rates
`ifndef SAP_DEFS_SVH
`define SAP_DEFS_SVH
// register byte offsets
`define SAP_OFF_CTRL 8'h00
`define SAP_OFF_CLKDIV 8'h04
`define SAP_OFF_MCLKDIV 8'h08
`define SAP_OFF_TXDATA 8'h0C
`define SAP_OFF_RXDATA 8'h10
`define SAP_OFF_STATUS 8'h14
// clock divider register fields
`define SAP_DIV_ODD_BIT 8
// status register fields
`define SAP_ST_TX_FULL 0
`define SAP_ST_TX_EMPTY 1
`define SAP_ST_RX_VALID 2
`define SAP_ST_RX_RIGHT 3
`define SAP_ST_TX_UNF 4
`define SAP_ST_RX_OVF 5
`define SAP_ST_WS 6
`define SAP_ST_LOCKED 7
// reset values, and the smallest divider that a written zero is lifted to
`define SAP_CTRL_RST 8'h00
`define SAP_DIV_RST 8'h04
`define SAP_MDIV_RST 8'h01
`define SAP_DIV_MIN 8'h01
// word lengths minus one, in bit clocks per channel
`define SAP_WLEN16_M1 6'h0F
`define SAP_WLEN32_M1 6'h1F
// rates that software has to reach through the dividers, and the depth of both fifos
`define SAP_SYS_CLK_HZ 20000000
`define SAP_FS_MIN_HZ 8000
`define SAP_FS_MAX_HZ 192000
`define SAP_MCLK_PER_FS 256
`define SAP_BCLK_PER_FS_MAX 64
`define SAP_FIFO_DEPTH 8
`endif

// ===== rtl/sap_pkg.sv
// serial audio port: shared types
`default_nettype none
package sap_pkg;
  // control register, bit 0 at the bottom
  typedef struct packed {
    logic dma_rx_en;
    logic dma_tx_en;
    logic mclk_en;
    logic word32;
    logic rx_en;
    logic tx_en;
    logic master;
    logic enable;
  } sap_ctrl_t;
  // one received channel word with its channel tag
  typedef struct packed {
    logic right;
    logic [31:0] data;
  } sap_word_t;
  // link lock state, one-hot
  typedef enum logic [2:0] {
    SAP_IDLE = 3'b001,
    SAP_SYNC = 3'b010,
    SAP_RUN = 3'b100
  } sap_state_t;
endpackage
`default_nettype wire

// ===== rtl/sap_fifo.sv
// serial audio port: small fifo with registered read data
`timescale 1ns/1ps
`default_nettype none
module sap_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, rd_q, rd_n;
  logic [AW:0] cnt_q;
  logic push, pop;
  // the count is one bit wider than the pointers, so a full queue is told apart from an empty one
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign rd_n = rd_q + AW'(pop);
  // storage, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
  // pointers and fill count
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_q + AW'(push);
      rd_q <= rd_n;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  // head word comes out of a register; bypass when writing into the new head
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      out_data <= '0;
    end else begin
      out_data <= (push && wr_q == rd_n) ? in_data : mem_q[rd_n];
    end
  end
endmodule // sap_fifo
`default_nettype wire

// ===== rtl/sap_top.sv
// serial audio port: registers, clock dividers, two-channel serial engine
`timescale 1ns/1ps
`default_nettype none
`include "sap_defs.svh"
// Contract
// [RQ1] master drives bit clock, word select; slave follows
// [RQ2] full duplex, transmit only or receive only
// [RQ3] word length 16 or 32 bits, shared
// [RQ4] sample rates 8 to 192 kHz supported; with 32-bit words the 20 MHz clock reaches at most 156.25 kHz
// [RQ5] master may output 256 Fs clock; it reaches at most 10 MHz, so 256 Fs only up to about 39 kHz
// [RQ6] 32-bit words: bit clock at most 64 Fs
// [RQ7] bit clock halves: divider, divider plus odd
// [RQ8] slave receiver bit clock duty 30-70 percent
// [RQ9] dma requests for transmit and receive words
// [RQ10] previous LSB follows select change; none first
// [RQ11] msb first, one clock late, low left
module sap_top
  import sap_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // dma requests
  output logic dma_tx_req,
  output logic dma_rx_req,
  // bit clock pin
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe,
  // word select pin
  input wire logic ws_i,
  output logic ws_o,
  output logic ws_oe,
  // serial data pins
  input wire logic sd_i,
  output logic sd_o,
  output logic sd_oe,
  // oversampling master clock
  output logic oversample_master_clock
);
  sap_ctrl_t ctrl_q;
  sap_state_t st_q;
  sap_word_t rx_word;
  logic [7:0] div_q, mdiv_q, mc_q;
  logic odd_q, tx_unf_q, rx_ovf_q, mclk_q, mclk_run;
  logic [31:0] rdata_q, rd_mux;
  logic [1:0] sck_sy_q, ws_sy_q, sd_sy_q;
  logic sck_dl_q, sck_oe_q, ws_oe_q, sd_oe_q, dtx_q, drx_q;
  logic run, mst, tx_on, rx_on, m_tog, rise, fall, chg;
  logic [8:0] hc_q, ph_len;
  logic sck_q, ws_q, ws_line, ws_last_q;
  logic [5:0] fcnt_q, wlen_m1, rcnt_q;
  logic [31:0] rsh_q, rsh_n, tsh_q, tword, tload;
  logic load_q, sd_q, rx_push, tx_pop;
  logic tx_in_ready, tx_out_valid, rx_in_ready, rx_out_valid, rx_pop;
  logic [31:0] tx_out_data;
  sap_word_t rx_out_data;

  assign run = ctrl_q.enable;
  assign mst = run & ctrl_q.master;
  assign tx_on = run & ctrl_q.tx_en; // [RQ2]
  assign rx_on = run & ctrl_q.rx_en; // [RQ2]
  assign wlen_m1 = ctrl_q.word32 ? `SAP_WLEN32_M1 : `SAP_WLEN16_M1; // [RQ3]

  // configuration writes; a zero divider would wrap to the longest half period instead of stopping, so it is lifted to one
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= sap_ctrl_t'(`SAP_CTRL_RST);
      div_q <= `SAP_DIV_RST;
      odd_q <= 1'b0;
      mdiv_q <= `SAP_MDIV_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        `SAP_OFF_CTRL: ctrl_q <= sap_ctrl_t'(reg_wdata[7:0]);
        `SAP_OFF_CLKDIV: begin
          div_q <= (reg_wdata[7:0] == 8'h00) ? `SAP_DIV_MIN : reg_wdata[7:0];
          odd_q <= reg_wdata[`SAP_DIV_ODD_BIT];
        end
        `SAP_OFF_MCLKDIV: mdiv_q <= (reg_wdata[7:0] == 8'h00) ? `SAP_DIV_MIN : reg_wdata[7:0];
        default: ;
      endcase
    end
  end

  // sticky error flags, write one to clear; a new event beats the clear
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_unf_q <= 1'b0;
      rx_ovf_q <= 1'b0;
    end else begin
      tx_unf_q <= (tx_on & fall & load_q & ~tx_out_valid) | (tx_unf_q &
                  ~(reg_wr && reg_addr == `SAP_OFF_STATUS && reg_wdata[`SAP_ST_TX_UNF]));
      rx_ovf_q <= (rx_push & ~rx_in_ready) | (rx_ovf_q &
                  ~(reg_wr && reg_addr == `SAP_OFF_STATUS && reg_wdata[`SAP_ST_RX_OVF]));
    end
  end

  // read mux; unmapped offsets read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (reg_addr)
      `SAP_OFF_CTRL: rd_mux = {24'h00_0000, ctrl_q};
      `SAP_OFF_CLKDIV: rd_mux = {23'h00_0000, odd_q, div_q};
      `SAP_OFF_MCLKDIV: rd_mux = {24'h00_0000, mdiv_q};
      `SAP_OFF_RXDATA: rd_mux = rx_out_valid ? rx_out_data.data : 32'h0000_0000;
      `SAP_OFF_STATUS: begin
        rd_mux[`SAP_ST_TX_FULL] = ~tx_in_ready;
        rd_mux[`SAP_ST_TX_EMPTY] = ~tx_out_valid;
        rd_mux[`SAP_ST_RX_VALID] = rx_out_valid;
        rd_mux[`SAP_ST_RX_RIGHT] = rx_out_valid & rx_out_data.right;
        rd_mux[`SAP_ST_TX_UNF] = tx_unf_q;
        rd_mux[`SAP_ST_RX_OVF] = rx_ovf_q;
        rd_mux[`SAP_ST_WS] = ws_line;
        rd_mux[`SAP_ST_LOCKED] = (st_q == SAP_RUN);
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // read data stand for exactly one cycle after the strobe
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end
  assign rx_pop = reg_rd && (reg_addr == `SAP_OFF_RXDATA);

  // pin synchronisers; stage 0 is read only by stage 1
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sck_sy_q <= 2'h0;
      ws_sy_q <= 2'h0;
      sd_sy_q <= 2'h0;
      sck_dl_q <= 1'b0;
    end else begin
      sck_sy_q <= {sck_sy_q[0], sck_i};
      ws_sy_q <= {ws_sy_q[0], ws_i};
      sd_sy_q <= {sd_sy_q[0], sd_i};
      sck_dl_q <= sck_sy_q[1];
    end
  end

  // bit clock divider: high lasts div, low lasts div plus odd
  assign ph_len = sck_q ? {1'b0, div_q} : ({1'b0, div_q} + {8'h00, odd_q}); // [RQ7]
  assign m_tog = mst & (hc_q >= ph_len - 9'h001);
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      hc_q <= 9'h000;
      sck_q <= 1'b0;
    end else if (!mst) begin
      hc_q <= 9'h000;
      sck_q <= 1'b0;
    end else if (m_tog) begin
      hc_q <= 9'h000;
      sck_q <= ~sck_q; // [RQ1] [RQ7]
    end else begin
      hc_q <= hc_q + 9'h001;
    end
  end

  // edge strobes; a slave clock must leave each half at least three sys_clk cycles
  assign rise = mst ? (m_tog & ~sck_q) : (run & sck_sy_q[1] & ~sck_dl_q); // [RQ8]
  assign fall = mst ? (m_tog & sck_q) : (run & ~sck_sy_q[1] & sck_dl_q); // [RQ8]

  // master word select: one change per channel of wlen bit clocks
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      fcnt_q <= 6'h00;
      ws_q <= 1'b1;
    end else if (!mst) begin
      fcnt_q <= wlen_m1; // first fall drops select to left
      ws_q <= 1'b1;
    end else if (fall) begin
      if (fcnt_q >= wlen_m1) begin
        fcnt_q <= 6'h00;
        ws_q <= ~ws_q; // [RQ4] [RQ6] [RQ11]
      end else begin
        fcnt_q <= fcnt_q + 6'h01;
      end
    end
  end

  // select seen at each rising edge; a change marks the last bit of a word
  assign ws_line = ctrl_q.master ? ws_q : ws_sy_q[1];
  assign chg = rise & (ws_line != ws_last_q);
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ws_last_q <= 1'b1;
    end else if (!run || rise) begin
      ws_last_q <= ws_line;
    end
  end

  // lock state: the first select change only aligns, it carries no word
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= SAP_IDLE;
    end else if (!run) begin
      st_q <= SAP_IDLE;
    end else begin
      case (st_q)
        SAP_IDLE: st_q <= SAP_SYNC;
        SAP_SYNC: if (chg) begin
          st_q <= SAP_RUN; // [RQ10]
        end
        SAP_RUN: st_q <= SAP_RUN;
        default: st_q <= SAP_IDLE;
      endcase
    end
  end

  // receiver: msb first, bits past the word length are ignored
  assign rsh_n = (rcnt_q <= wlen_m1) ? {rsh_q[30:0], sd_sy_q[1]} : rsh_q; // [RQ11]
  assign rx_push = rx_on & chg & (st_q == SAP_RUN); // [RQ10]
  assign rx_word.right = ws_last_q; // select high was the right channel
  assign rx_word.data = ctrl_q.word32 ? rsh_n : {16'h0000, rsh_n[15:0]}; // [RQ3]
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rsh_q <= 32'h0000_0000;
      rcnt_q <= 6'h00;
    end else if (!rx_on || chg) begin
      rsh_q <= 32'h0000_0000;
      rcnt_q <= 6'h00;
    end else if (rise) begin
      rsh_q <= rsh_n;
      rcnt_q <= (rcnt_q <= wlen_m1) ? rcnt_q + 6'h01 : rcnt_q;
    end
  end

  // transmitter: load after a select change, shift on falling edges
  assign tword = tx_out_valid ? tx_out_data : 32'h0000_0000; // underrun sends silence
  assign tload = ctrl_q.word32 ? tword : {tword[15:0], 16'h0000}; // [RQ3]
  assign tx_pop = tx_on & fall & load_q;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      load_q <= 1'b0;
      tsh_q <= 32'h0000_0000;
      sd_q <= 1'b0;
    end else if (!tx_on) begin
      load_q <= 1'b0;
      tsh_q <= 32'h0000_0000;
      sd_q <= 1'b0;
    end else begin
      if (chg) begin
        load_q <= 1'b1;
      end else if (fall) begin
        load_q <= 1'b0;
      end
      if (fall && load_q) begin
        sd_q <= tload[31]; // [RQ11]
        tsh_q <= {tload[30:0], 1'b0};
      end else if (fall) begin
        sd_q <= tsh_q[31]; // [RQ10]
        tsh_q <= {tsh_q[30:0], 1'b0};
      end
    end
  end

  // oversampling clock divider, toggles every mdiv cycles
  assign mclk_run = mst & ctrl_q.mclk_en;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mc_q <= 8'h00;
      mclk_q <= 1'b0;
    end else if (!mclk_run) begin
      mc_q <= 8'h00;
      mclk_q <= 1'b0;
    end else if (mc_q >= mdiv_q - 8'h01) begin
      mc_q <= 8'h00;
      mclk_q <= ~mclk_q; // [RQ5]
    end else begin
      mc_q <= mc_q + 8'h01;
    end
  end

  // pin enables and dma requests; requests lag the fifo by one cycle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sck_oe_q <= 1'b0;
      ws_oe_q <= 1'b0;
      sd_oe_q <= 1'b0;
      dtx_q <= 1'b0;
      drx_q <= 1'b0;
    end else begin
      sck_oe_q <= mst; // [RQ1]
      ws_oe_q <= mst; // [RQ1]
      sd_oe_q <= tx_on; // [RQ2]
      dtx_q <= tx_on & ctrl_q.dma_tx_en & tx_in_ready; // [RQ9]
      drx_q <= rx_on & ctrl_q.dma_rx_en & rx_out_valid & ~rx_pop; // [RQ9]
    end
  end

  // transmit words queue; software or dma fills, serializer drains
  sap_fifo #(.WIDTH(32), .DEPTH(`SAP_FIFO_DEPTH)) u_tx_fifo (
    .clk(sys_clk),
    .reset_n(reset_n),
    .in_valid(reg_wr && reg_addr == `SAP_OFF_TXDATA),
    .in_ready(tx_in_ready),
    .in_data(reg_wdata),
    .out_valid(tx_out_valid),
    .out_ready(tx_pop),
    .out_data(tx_out_data)
  );

  // received words queue; a full queue drops the word and flags overrun
  sap_fifo #(.WIDTH($bits(sap_word_t)), .DEPTH(`SAP_FIFO_DEPTH)) u_rx_fifo (
    .clk(sys_clk),
    .reset_n(reset_n),
    .in_valid(rx_push),
    .in_ready(rx_in_ready),
    .in_data(rx_word),
    .out_valid(rx_out_valid),
    .out_ready(rx_pop),
    .out_data(rx_out_data)
  );

  assign reg_rdata = rdata_q;
  assign dma_tx_req = dtx_q;
  assign dma_rx_req = drx_q;
  assign sck_o = sck_q;
  assign sck_oe = sck_oe_q;
  assign ws_o = ws_q;
  assign ws_oe = ws_oe_q;
  assign sd_o = sd_q;
  assign sd_oe = sd_oe_q;
  assign oversample_master_clock = mclk_q;

  // checking helpers: phase lengths and falls per channel
  logic [8:0] ah_q;
  logic [7:0] am_q;
  logic [6:0] af_q;
  logic sck_pa_q, ws_pa_q, mclk_pa_q;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ah_q <= 9'h000;
      am_q <= 8'h00;
      af_q <= 7'h00;
      sck_pa_q <= 1'b0;
      ws_pa_q <= 1'b1;
      mclk_pa_q <= 1'b0;
    end else begin
      sck_pa_q <= sck_q;
      ws_pa_q <= ws_q;
      mclk_pa_q <= mclk_q;
      ah_q <= !mst ? 9'h000 : (sck_q != sck_pa_q) ? 9'h001 : ah_q + 9'h001;
      am_q <= !mclk_run ? 8'h00 : (mclk_q != mclk_pa_q) ? 8'h01 : am_q + 8'h01;
      af_q <= !mst ? 7'h00 : (ws_q != ws_pa_q) ? 7'h00 : af_q + {6'h00, fall};
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  property p_sck_high; mst && $fell(sck_q) |-> ah_q == {1'b0, div_q}; endproperty
  a_sck_high: assert property (p_sck_high) else $error("bit clock high phase wrong"); // RQ7
  property p_sck_low; mst && $rose(sck_q) |-> ah_q == {1'b0, div_q} + {8'h00, odd_q}; endproperty
  a_sck_low: assert property (p_sck_low) else $error("bit clock low phase wrong"); // RQ7
  property p_ws_slot; mst && $changed(ws_q) && st_q == SAP_RUN |-> af_q == {1'b0, wlen_m1} + 7'h01;
  endproperty
  a_ws_slot: assert property (p_ws_slot) else $error("channel slot length wrong"); // RQ6
  property p_ws_on_fall; mst && $past(mst) && $changed(ws_q) |-> $past(fall); endproperty
  a_ws_on_fall: assert property (p_ws_on_fall) else $error("select moved off a fall"); // RQ4
  property p_msb_first; tx_on && fall && load_q |=> sd_q == $past(tload[31]); endproperty
  a_msb_first: assert property (p_msb_first) else $error("word did not start msb"); // RQ11
  property p_lsb_after; rx_push && ctrl_q.word32 && rcnt_q == 6'h1F |-> rx_word.data[0] == sd_sy_q[1];
  endproperty
  a_lsb_after: assert property (p_lsb_after) else $error("trailing bit not captured"); // RQ10
  property p_no_first; st_q != SAP_RUN |-> !rx_push; endproperty
  a_no_first: assert property (p_no_first) else $error("word pushed before lock"); // RQ10
  property p_roles; ##1 1'b1 |-> sck_oe == $past(mst) && ws_oe == $past(mst); endproperty
  a_roles: assert property (p_roles) else $error("clock drive does not follow role"); // RQ1
  property p_dir; !tx_on |=> !sd_oe && !sd_o; endproperty
  a_dir: assert property (p_dir) else $error("data driven while transmit off"); // RQ2
  property p_mclk; mclk_run && $changed(mclk_q) |-> am_q == mdiv_q; endproperty
  a_mclk: assert property (p_mclk) else $error("master clock half period wrong"); // RQ5
  property p_dma; tx_on && ctrl_q.dma_tx_en && tx_in_ready |=> dma_tx_req; endproperty
  a_dma: assert property (p_dma) else $error("transmit dma request missing"); // RQ9
  property p_wlen16; rx_push && !ctrl_q.word32 |-> rx_word.data[31:16] == 16'h0000; endproperty
  a_wlen16: assert property (p_wlen16) else $error("16-bit word has upper bits"); // RQ3

  c_master_rx: cover property (rx_push && ctrl_q.master);
  c_slave_rx: cover property (rx_push && !ctrl_q.master);
  c_underrun: cover property ($rose(tx_unf_q));
  c_duplex16: cover property (rx_push && tx_pop && !ctrl_q.word32);
endmodule // sap_top
`default_nettype wire

// ===== dv/sap_codec_model.sv
// serial audio port: behavioural external codec on the far side of the link
`timescale 1ns/1ps
`default_nettype none
module sap_codec_model #(
  parameter logic [31:0] LEFT_WORD = 32'h13579BDF,
  parameter logic [31:0] RIGHT_WORD = 32'h2468ACE0
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // mode
  input wire logic gen,
  input wire logic word32,
  // link wires
  input wire logic sck,
  input wire logic ws,
  input wire logic sd_o,
  output logic sd_i,
  output logic sck_g,
  output logic ws_g
);
  logic sck_q, ws_r, ws_f, run;
  logic [31:0] sh, sr;
  logic [31:0] cap [0:7];
  int n, hc, fc;

  // receive on rise, transmit on fall; words close where a rise sees a select change
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_q <= 1'h0;
      ws_r <= 1'h1;
      ws_f <= 1'h1;
      run <= 1'h0;
      n <= 0;
      sh <= 32'h0;
      sr <= 32'h0;
      sd_i <= 1'h0;
    end else begin
      sck_q <= sck;
      if (sck && !sck_q) begin
        sh <= {sh[30:0], sd_o};
        ws_r <= ws;
        if (ws != ws_r) begin
          run <= 1'h1;
          sh <= 32'h0;
          if (run && n < 8) begin
            cap[n] <= {sh[30:0], sd_o};
            n <= n + 1;
          end
        end
      end
      if (!sck && sck_q) begin
        sd_i <= sr[31];
        sr <= {sr[30:0], 1'h0};
        ws_f <= ws;
        // low select is the left channel; short words sit at the top
        if (ws != ws_f) sr <= (ws ? RIGHT_WORD : LEFT_WORD) << (word32 ? 0 : 16);
      end
    end
  end

  // bit clock maker for slave runs: halves of five cycles, well inside the duty window
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hc <= 0;
      fc <= 15;
      sck_g <= 1'h0;
      ws_g <= 1'h1;
    end else if (!gen) begin
      hc <= 0;
      fc <= word32 ? 31 : 15;
      sck_g <= 1'h0; // stands still outside frames
      ws_g <= 1'h1;
    end else begin
      hc <= (hc == 4) ? 0 : hc + 1;
      if (hc == 4) begin
        sck_g <= !sck_g;
        if (sck_g) begin
          fc <= (fc == (word32 ? 31 : 15)) ? 0 : fc + 1;
          if (fc == (word32 ? 31 : 15)) ws_g <= !ws_g;
        end
      end
    end
  end
endmodule // sap_codec_model
`default_nettype wire

// ===== dv/testbench.sv
// serial audio port: self-checking testbench
`timescale 1ns/1ps
`default_nettype none
`include "sap_defs.svh"
module testbench;
  logic sys_clk = 1'h0;
  logic reset_n, reg_wr, reg_rd, m_rst_n, gen, w32, msel;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d, s;
  logic dma_tx_req, dma_rx_req, sck_o, sck_oe, ws_o, ws_oe, sd_o, sd_oe, mclk;
  logic sd_m, sck_g, ws_g, sck_w, ws_w, sd_w, mon;
  int miscompares, n_tests, c, i;

  // wire levels from the port's output enables; a released data line wiggles
  assign sck_w = sck_oe ? sck_o : sck_g;
  assign ws_w = ws_oe ? ws_o : ws_g;
  assign sd_w = sd_oe ? sd_o : sys_clk;
  assign mon = msel ? mclk : sck_o;

  always #25 sys_clk = ~sys_clk;

  sap_top u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .dma_tx_req(dma_tx_req), .dma_rx_req(dma_rx_req), .sck_i(sck_w), .sck_o(sck_o),
    .sck_oe(sck_oe), .ws_i(ws_w), .ws_o(ws_o), .ws_oe(ws_oe), .sd_i(sd_m), .sd_o(sd_o),
    .sd_oe(sd_oe), .oversample_master_clock(mclk));

  sap_codec_model u_codec (.sys_clk(sys_clk), .rst_n(m_rst_n), .gen(gen), .word32(w32),
    .sck(sck_w), .ws(ws_w), .sd_o(sd_w), .sd_i(sd_m), .sck_g(sck_g), .ws_g(ws_g));

  task automatic final_report;
    if (miscompares == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'h1;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    #1;
    v = reg_rdata;
  endtask

  // length in cycles of the next half of level v on the monitored clock
  task automatic halfw(input logic v, output int n);
    int k;
    n = 0;
    for (k = 0; k < 50 && mon !== ~v; k++) begin
      @(posedge sys_clk);
      #1;
    end
    for (k = 0; k < 50 && mon !== v; k++) begin
      @(posedge sys_clk);
      #1;
    end
    for (k = 0; k < 50 && mon === v; k++) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
  endtask

  task automatic rxc(input logic [31:0] l, input logic [31:0] r);
    rd(`SAP_OFF_STATUS, s);
    rd(`SAP_OFF_RXDATA, d);
    chk("rx word", d, s[`SAP_ST_RX_RIGHT] ? r : l);
  endtask

  task automatic restart_codec;
    m_rst_n <= 1'h0;
    @(posedge sys_clk);
    m_rst_n <= 1'h1;
  endtask

  function automatic logic [31:0] tw(input int k);
    return 32'hC3A50000 | (32'(k + 1) * 32'h1111);
  endfunction

  // hang guard, well beyond the roughly 4000 cycles the tests take
  initial begin
    repeat (30000) @(posedge sys_clk);
    miscompares++;
    final_report();
  end

  initial begin
    reset_n = 1'h0;
    m_rst_n = 1'h0;
    reg_addr = 8'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    gen = 1'h0;
    w32 = 1'h0;
    msel = 1'h0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'h1;
    m_rst_n <= 1'h1;
    // reset values and an unmapped address
    rd(`SAP_OFF_CTRL, d);
    chk("ctrl", d, 32'(`SAP_CTRL_RST));
    rd(`SAP_OFF_CLKDIV, d);
    chk("clkdiv", d, 32'(`SAP_DIV_RST));
    rd(`SAP_OFF_MCLKDIV, d);
    chk("mclkdiv", d, 32'(`SAP_MDIV_RST));
    rd(8'h20, d);
    chk("unmapped", d, 32'h0);
    rd(`SAP_OFF_STATUS, d);
    chk("status", d & 32'h3F, 32'h02);
    // uneven bit clock halves as master
    wr(`SAP_OFF_CLKDIV, 32'h103);
    wr(`SAP_OFF_CTRL, 32'h03);
    halfw(1'h1, c);
    chk("sck high", 32'(c), 32'h3);
    halfw(1'h0, c);
    chk("sck low", 32'(c), 32'h4);
    chk("sck oe", 32'(sck_oe), 32'h1);
    // oversampling clock
    wr(`SAP_OFF_MCLKDIV, 32'h2);
    wr(`SAP_OFF_CTRL, 32'h23);
    msel = 1'h1;
    halfw(1'h1, c);
    chk("mclk high", 32'(c), 32'h2);
    halfw(1'h0, c);
    chk("mclk low", 32'(c), 32'h2);
    chk("sd oe off", 32'(sd_oe), 32'h0);
    // fill the transmit fifo until it refuses, then run master duplex 16-bit with dma
    wr(`SAP_OFF_CTRL, 32'h0);
    wr(`SAP_OFF_CLKDIV, 32'h4);
    for (i = 0; i < 9; i++) wr(`SAP_OFF_TXDATA, tw(i));
    rd(`SAP_OFF_STATUS, d);
    chk("tx full", 32'(d[`SAP_ST_TX_FULL]), 32'h1);
    restart_codec();
    wr(`SAP_OFF_CTRL, 32'hCF);
    repeat (3) @(posedge sys_clk);
    #1;
    chk("dma tx full", 32'(dma_tx_req), 32'h0);
    repeat (1600) @(posedge sys_clk);
    #1;
    chk("dma tx", 32'(dma_tx_req), 32'h1);
    chk("dma rx", 32'(dma_rx_req), 32'h1);
    for (i = 0; i < 8; i++) chk("tx word", u_codec.cap[i], tw(i) & 32'hFFFF);
    rd(`SAP_OFF_STATUS, d);
    chk("run flags", d & 32'h33, 32'h32);
    rxc(32'h9BDF, 32'hACE0);
    wr(`SAP_OFF_CTRL, 32'h0);
    wr(`SAP_OFF_STATUS, 32'h30);
    rd(`SAP_OFF_STATUS, d);
    chk("flags clear", d & 32'h30, 32'h0);
    repeat (8) rd(`SAP_OFF_RXDATA, d);
    rd(`SAP_OFF_STATUS, d);
    chk("rx drained", 32'(d[`SAP_ST_RX_VALID]), 32'h0);
    // 32-bit words as master
    w32 <= 1'h1;
    restart_codec();
    wr(`SAP_OFF_TXDATA, tw(0));
    wr(`SAP_OFF_TXDATA, tw(1));
    wr(`SAP_OFF_CTRL, 32'h1F);
    repeat (1400) @(posedge sys_clk);
    chk("tx32 left", u_codec.cap[0], tw(0));
    chk("tx32 right", u_codec.cap[1], tw(1));
    rxc(32'h13579BDF, 32'h2468ACE0);
    wr(`SAP_OFF_CTRL, 32'h0);
    repeat (8) rd(`SAP_OFF_RXDATA, d);
    // slave duplex: the codec makes bit clock and word select
    w32 <= 1'h0;
    restart_codec();
    wr(`SAP_OFF_TXDATA, tw(2));
    wr(`SAP_OFF_TXDATA, tw(3));
    wr(`SAP_OFF_CTRL, 32'h0D);
    gen <= 1'h1;
    repeat (800) @(posedge sys_clk);
    chk("slave left", u_codec.cap[0], tw(2) & 32'hFFFF);
    chk("slave right", u_codec.cap[1], tw(3) & 32'hFFFF);
    chk("slave oe", {30'h0, sck_oe, ws_oe}, 32'h0);
    rxc(32'h9BDF, 32'hACE0);
    gen <= 1'h0;
    final_report();
  end
endmodule // testbench
`default_nettype wire
